/* File: core/luc_ctrl.sv */
// lin/uart serial controller with an axi4-lite register slave
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "luc_cfg.svh"
// Behaviour
// - command bit 2 set selects uart services instead of lin commands
// - low command bits pick byte transfer, transmit, receive or full duplex
// - uart mode bypasses the fifo; data is a single plain register
// - received character sets rx complete; data read or direct clear drops it
// - two-stage receive; overwrite of full holding byte flags overrun
// - framing error on receive sets the framing flag
// - data write starts transmit, clears tx complete; set again at end
// - core reset clears all but timing and identifier, which load 0x20 and 0x80; self-clearing soft reset clears most registers
// - soft reset keeps divisors, clears low nibbles, restores timing and identifier
// - single system clock drives everything
// - version bit picks lin 2.1 or 1.3, ignored in uart mode; here the bit is only stored and read back
// - lin config: standard, no checksum, no timeout, listening; here only listening has an effect
// - uart config: no parity, even, odd, or listening without parity
// - listening loops transmit to receive and idles the output pin
// - read-only busy flag mirrors internal busy, hardware driven
// - lin busy locks control extras, divisors, length, identifier, data
// - lin busy abort ends after byte; disable or soft reset immediate
// - other commands while busy rejected with overrun flag
// - uart busy only while transmitting; locks data and control extras
// - bit rate is clock over samples per bit times divisor plus one
// - each received bit decided by majority of three samples
// - lin response bytes pass a fifo walked by successive data accesses
// - enable bit activates; clearing it disables at once
// - command bit 2 clear interprets low bits as lin commands
module luc_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             busy_flag
);

  // ****************************************
  // functions
  // ****************************************

  // address matches a register word
  function automatic logic reg_hit(input logic [5:0] addr, input logic [5:0] off);
    reg_hit = (addr[5:2] == off[5:2]);
  endfunction

  // majority of three samples
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
  endfunction

  // response length limited to 1..8 bytes
  function automatic logic [3:0] len_clamp(input logic [3:0] n);
    len_clamp = (n == 4'h0) ? 4'h1 : ((n > 4'h8) ? 4'h8 : n);
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  logic                 aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [5:0]           aw_addr_r;
  logic [7:0]           w_data_r;
  logic                 w_strb_r;
  logic [1:0]           bresp_r, rresp_r;
  logic [31:0]          rdata_r;
  logic [2:0]           cmd_r;
  logic                 ena_r, ver_r;
  logic [1:0]           conf_r;
  logic                 rx_ok_r, tx_ok_r, err_frame_r, err_ovr_r, err_abort_r;
  logic [7:0]           ien_r, btr_r, divl_r, len_r, ident_r, sel_r, data_r;
  logic [3:0]           divh_r, cnt_r;
  logic                 abort_pend_r;
  luc_pkg::luc_lin_state_t ls_r;
  logic [7:0]           fifo_r [0:7];
  logic [11:0]          div_cnt_r;
  logic                 tx_act_r;
  logic [10:0]          tx_sh_r;
  logic [3:0]           tx_left_r;
  logic [5:0]           tx_scnt_r;
  logic                 rx_sync1_r, rx_sync2_r, rx_prev_r, rx_act_r;
  logic [3:0]           rx_idx_r;
  logic [5:0]           rx_scnt_r;
  logic [2:0]           rx_vote_r;
  logic [7:0]           rx_sh_r;
  logic                 out_r;
  logic [7:0]           rd_vec [0:15];

  // ****************************************
  // bus decode
  // ****************************************

  // write and read strobes
  wire wr_do     = ce & aw_hold_r & w_hold_r & ~bvalid_r;
  wire wr_en     = wr_do & w_strb_r;
  wire rd_do     = ce & s_axi_arvalid & ~rvalid_r;
  wire ctl_wr    = wr_en & reg_hit(aw_addr_r, `LUC_OFF_CTRL);
  wire stat_wr   = wr_en & reg_hit(aw_addr_r, `LUC_OFF_STAT);
  wire data_wr   = wr_en & reg_hit(aw_addr_r, `LUC_OFF_DATA);
  wire data_rd   = rd_do & reg_hit(s_axi_araddr, `LUC_OFF_DATA);
  wire [7:0] wv  = w_data_r;

  // ****************************************
  // mode and busy
  // ****************************************

  // mode selection
  // command bit 2 picks uart
  wire uart_mode = cmd_r[`LUC_CTRL_CMD2];
  wire lin_busy  = (ls_r != luc_pkg::LS_IDLE);
  wire uart_busy = uart_mode & tx_act_r;
  wire busy      = lin_busy | uart_busy;
  wire listen    = (conf_r == 2'b11);
  wire par_on    = uart_mode & (conf_r == 2'b01 | conf_r == 2'b10);
  wire par_odd   = (conf_r == 2'b10);
  wire sw_reset  = ctl_wr & wv[`LUC_CTRL_SWRES];
  wire lin_start = wv[`LUC_CTRL_ENA] & ~wv[`LUC_CTRL_CMD2] & (wv[1:0] != 2'b00);
  wire [3:0] tx_len = len_clamp(len_r[7:4]);
  wire [3:0] rx_len = len_clamp(len_r[3:0]);
  wire [3:0] cnt_inc = cnt_r + 4'h1;

  // transmit start and kill
  // code bit 0 transmits
  wire uart_tx_go = data_wr & uart_mode & ena_r & cmd_r[0] & ~tx_act_r;
  wire lin_tx_go  = ce & ena_r & ~tx_act_r &
                    (ls_r == luc_pkg::LS_THDR | ls_r == luc_pkg::LS_TRSP);
  wire tx_go      = uart_tx_go | lin_tx_go;
  wire tx_kill    = sw_reset | (ctl_wr & ~wv[`LUC_CTRL_ENA]) |
                    (ctl_wr & uart_mode & ~wv[`LUC_CTRL_CMD2]);
  wire [7:0] tx_byte = uart_mode ? wv :
                       ((ls_r == luc_pkg::LS_THDR) ? ident_r : fifo_r[cnt_r[2:0]]);
  wire tx_par     = (^tx_byte) ^ par_odd;

  // receive enable follows the selected service
  // service selects receive
  wire rx_en = ena_r & (uart_mode ? cmd_r[1] : (ls_r == luc_pkg::LS_RRSP));

  // fifo access by software in lin mode
  wire fifo_wr  = data_wr & ~uart_mode & ~lin_busy;
  wire fifo_acc = fifo_wr | (data_rd & ~uart_mode);
  wire rx_clr   = (data_rd & uart_mode) | (stat_wr & wv[`LUC_STAT_RXOK]);

  // ****************************************
  // baud generator
  // ****************************************

  wire [11:0] baud_div = {divh_r, divl_r};
  wire        tick     = ce & ena_r & (div_cnt_r == baud_div);
  wire [5:0]  spb      = btr_r[5:0];
  wire [5:0]  spb_last = spb - 6'h01;
  wire [5:0]  spb_mid  = {1'b0, spb[5:1]};

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !ena_r) begin
      div_cnt_r <= 12'h000;
    end else if (ce) begin
      div_cnt_r <= (div_cnt_r == baud_div) ? 12'h000 : div_cnt_r + 12'h001;
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  wire tx_bit_end = tx_act_r & tick & (tx_scnt_r == spb_last);
  wire tx_done    = tx_bit_end & (tx_left_r == 4'h1);
  wire tx_line    = tx_sh_r[0];

  always_ff @(posedge sys_clk) begin
    if (!rst_n || tx_kill) begin
      tx_act_r  <= 1'b0;
      tx_sh_r   <= 11'h7ff;
      tx_left_r <= 4'h0;
      tx_scnt_r <= 6'h00;
    end else if (ce) begin
      if (tx_go) begin
        tx_act_r  <= 1'b1;
        tx_sh_r   <= {1'b1, par_on ? tx_par : 1'b1, tx_byte, 1'b0};
        tx_left_r <= par_on ? 4'hb : 4'ha;
        tx_scnt_r <= 6'h00;
      end else if (tx_bit_end) begin
        tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
        tx_left_r <= tx_left_r - 4'h1;
        tx_scnt_r <= 6'h00;
        if (tx_left_r == 4'h1) tx_act_r <= 1'b0;
      end else if (tx_act_r && tick) begin
        tx_scnt_r <= tx_scnt_r + 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      out_r <= 1'b1;
    end else if (ce) begin
      out_r <= listen ? 1'b1 : tx_line;
    end
  end

  // ****************************************
  // receiver
  // ****************************************

  // two-stage pin synchroniser
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_sync1_r <= 1'b1;
      rx_sync2_r <= 1'b1;
    end else if (ce) begin
      rx_sync1_r <= serial_in_pin;
      rx_sync2_r <= rx_sync1_r;
    end
  end

  wire       rx_src     = listen ? tx_line : rx_sync2_r;
  wire       rx_bit_end = rx_act_r & tick & (rx_scnt_r == spb_last);
  wire       rx_bit     = maj3(rx_vote_r);
  wire [3:0] rx_last    = par_on ? 4'ha : 4'h9;
  wire       rx_done    = rx_bit_end & (rx_idx_r == rx_last);
  wire       rx_framing_flag    = ~rx_bit;
  wire       rx_samp    = tick & ((rx_scnt_r == spb_mid - 6'h01) | (rx_scnt_r == spb_mid) |
                                  (rx_scnt_r == spb_mid + 6'h01));

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !rx_en || sw_reset) begin
      rx_act_r  <= 1'b0;
      rx_prev_r <= 1'b1;
      rx_idx_r  <= 4'h0;
      rx_scnt_r <= 6'h00;
      rx_vote_r <= 3'h7;
      rx_sh_r   <= 8'h00;
    end else if (ce) begin
      rx_prev_r <= rx_src;
      if (!rx_act_r) begin
        if (rx_prev_r && !rx_src) begin
          rx_act_r  <= 1'b1;
          rx_idx_r  <= 4'h0;
          rx_scnt_r <= 6'h00;
        end
      end else begin
        if (rx_samp) rx_vote_r <= {rx_vote_r[1:0], rx_src};
        if (rx_bit_end) begin
          rx_scnt_r <= 6'h00;
          rx_idx_r  <= rx_idx_r + 4'h1;
          if (rx_idx_r >= 4'h1 && rx_idx_r <= 4'h8) rx_sh_r <= {rx_bit, rx_sh_r[7:1]};
          if ((rx_idx_r == 4'h0 && rx_bit) || rx_done) rx_act_r <= 1'b0;
        end else if (tick) begin
          rx_scnt_r <= rx_scnt_r + 6'h01;
        end
      end
    end
  end

  // ****************************************
  // response fifo
  // ****************************************
  wire rx_store = rx_done & ~uart_mode & (ls_r == luc_pkg::LS_RRSP) & ~rx_framing_flag;

  // one flop byte per fifo entry
  for (genvar i = 0; i < 8; i++) begin : g_fifo
    always_ff @(posedge sys_clk) begin
      if (!rst_n || sw_reset) begin
        fifo_r[i] <= `LUC_RST_ZERO;
      end else if (ce) begin
        if (rx_store && cnt_r == 4'(i)) begin
          fifo_r[i] <= rx_sh_r;
        end else if (fifo_wr && sel_r[2:0] == 3'(i)) begin
          fifo_r[i] <= wv;
        end
      end
    end
  end

  // ****************************************
  // registers and lin sequencer
  // ****************************************
  // core reset clears all but btr_r and ident_r, which load their defaults
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmd_r <= 3'h0; ena_r <= 1'b0; conf_r <= 2'h0; ver_r <= 1'b0;
      rx_ok_r <= 1'b0; tx_ok_r <= 1'b0;
      err_frame_r <= 1'b0; err_ovr_r <= 1'b0; err_abort_r <= 1'b0;
      ien_r <= `LUC_RST_ZERO; btr_r <= `LUC_RST_BTR; divl_r <= `LUC_RST_ZERO;
      divh_r <= 4'h0; len_r <= `LUC_RST_ZERO; ident_r <= `LUC_RST_IDENT;
      sel_r <= `LUC_RST_ZERO; data_r <= `LUC_RST_ZERO;
      ls_r <= luc_pkg::LS_IDLE; cnt_r <= 4'h0; abort_pend_r <= 1'b0;
    end else if (ce) begin
      if (sw_reset) begin
        cmd_r <= 3'h0; ena_r <= 1'b0; conf_r <= 2'h0; ver_r <= 1'b0;
        rx_ok_r <= 1'b0; tx_ok_r <= 1'b0;
        err_frame_r <= 1'b0; err_ovr_r <= 1'b0; err_abort_r <= 1'b0;
        ien_r[3:0] <= 4'h0; btr_r <= `LUC_RST_BTR; len_r <= `LUC_RST_ZERO;
        ident_r <= `LUC_RST_IDENT; sel_r[3:0] <= 4'h0; data_r <= `LUC_RST_ZERO;
        ls_r <= luc_pkg::LS_IDLE; cnt_r <= 4'h0; abort_pend_r <= 1'b0;
      end else begin
        // flag clears come first so sets win
        if (rx_clr) rx_ok_r <= 1'b0;
        if (stat_wr && wv[`LUC_STAT_TXOK]) tx_ok_r <= 1'b0;
        if (stat_wr && wv[`LUC_STAT_ERR]) begin
          err_frame_r <= 1'b0;
          err_ovr_r   <= 1'b0;
          err_abort_r <= 1'b0;
        end
        if (uart_tx_go) tx_ok_r <= 1'b0;
        // control writes
        if (ctl_wr) begin
          if (lin_busy) begin
            // disable kills, abort waits for the byte end
            if (!wv[`LUC_CTRL_ENA]) begin
              ena_r <= 1'b0;
              cmd_r <= wv[2:0];
              ls_r  <= luc_pkg::LS_IDLE;
            end else if (wv[2:0] == 3'h0) begin
              abort_pend_r <= 1'b1;
            end else begin
              err_ovr_r <= 1'b1;
            end
          end else begin
            cmd_r <= wv[2:0];
            ena_r <= wv[`LUC_CTRL_ENA];
            if (!uart_busy) begin
              conf_r <= wv[`LUC_CTRL_CONF +: 2];
              ver_r  <= wv[`LUC_CTRL_VER];
            end
            if (lin_start) begin
              cnt_r        <= 4'h0;
              abort_pend_r <= 1'b0;
              case (wv[1:0])
                2'b01:   ls_r <= luc_pkg::LS_THDR;
                2'b11:   ls_r <= luc_pkg::LS_TRSP;
                2'b10:   ls_r <= luc_pkg::LS_RRSP;
                default: ls_r <= luc_pkg::LS_IDLE;
              endcase
            end
          end
        end
        // plain registers; lin busy lock
        if (wr_en && reg_hit(aw_addr_r, `LUC_OFF_IEN)) ien_r <= wv;
        if (wr_en && reg_hit(aw_addr_r, `LUC_OFF_BTR)) btr_r <= wv;
        if (wr_en && !lin_busy && reg_hit(aw_addr_r, `LUC_OFF_DIVL)) divl_r <= wv;
        if (wr_en && !lin_busy && reg_hit(aw_addr_r, `LUC_OFF_DIVH)) divh_r <= wv[3:0];
        if (wr_en && !lin_busy && reg_hit(aw_addr_r, `LUC_OFF_IDENT)) ident_r <= wv;
        if (wr_en && !lin_busy && !uart_mode && reg_hit(aw_addr_r, `LUC_OFF_LEN)) len_r <= wv;
        if (uart_mode) len_r <= `LUC_RST_ZERO;
        // index walks with each data access
        if (fifo_acc && !sel_r[`LUC_SEL_NOINC]) sel_r[2:0] <= sel_r[2:0] + 3'h1;
        if (wr_en && reg_hit(aw_addr_r, `LUC_OFF_SEL)) sel_r <= wv;
        if (uart_mode && rx_done) begin
          data_r  <= rx_sh_r;
          rx_ok_r <= 1'b1;
          if (rx_ok_r && !rx_clr) err_ovr_r <= 1'b1;
        end
        if (rx_done && rx_framing_flag) err_frame_r <= 1'b1;
        if (uart_mode && tx_done) tx_ok_r <= 1'b1;
        // lin sequencer progress
        case (ls_r)
          luc_pkg::LS_THDR: begin
            if (tx_done) begin
              ls_r  <= luc_pkg::LS_IDLE;
              cmd_r <= 3'h0;
              if (abort_pend_r) err_abort_r <= 1'b1;
            end
          end
          luc_pkg::LS_TRSP: begin
            if (tx_done) begin
              cnt_r <= cnt_inc;
              if (abort_pend_r || cnt_inc == tx_len) begin
                ls_r  <= luc_pkg::LS_IDLE;
                cmd_r <= 3'h0;
              end
              if (abort_pend_r) err_abort_r <= 1'b1;
              else if (cnt_inc == tx_len) tx_ok_r <= 1'b1;
            end
          end
          luc_pkg::LS_RRSP: begin
            if (rx_done) begin
              cnt_r <= cnt_inc;
              if (rx_framing_flag || abort_pend_r || cnt_inc == rx_len) begin
                ls_r  <= luc_pkg::LS_IDLE;
                cmd_r <= 3'h0;
              end
              if (!rx_framing_flag && abort_pend_r) err_abort_r <= 1'b1;
              else if (!rx_framing_flag && cnt_inc == rx_len) rx_ok_r <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************

  // read value per register word
  assign rd_vec[0]  = {1'b0, ver_r, conf_r, ena_r, cmd_r};
  assign rd_vec[1]  = {3'h0, busy, err_frame_r | err_ovr_r | err_abort_r, 1'b0, tx_ok_r, rx_ok_r};
  assign rd_vec[2]  = ien_r;
  assign rd_vec[3]  = {err_abort_r, 1'b0, err_ovr_r, 1'b0, err_frame_r, 3'h0};
  assign rd_vec[4]  = btr_r;
  assign rd_vec[5]  = divl_r;
  assign rd_vec[6]  = {4'h0, divh_r};
  assign rd_vec[7]  = uart_mode ? `LUC_RST_ZERO : len_r;
  assign rd_vec[8]  = ident_r;
  assign rd_vec[9]  = sel_r;
  assign rd_vec[10] = uart_mode ? data_r : fifo_r[sel_r[2:0]];
  for (genvar j = 11; j < 16; j++) begin : g_unmapped
    assign rd_vec[j] = `LUC_RST_ZERO;
  end

  // handshake outputs
  assign s_axi_awready = ~aw_hold_r;
  assign s_axi_wready  = ~w_hold_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign serial_out_pin = out_r;
  assign busy_flag     = busy;

  // write channel capture and response
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_hold_r <= 1'b0; w_hold_r <= 1'b0; bvalid_r <= 1'b0;
      aw_addr_r <= 6'h00; w_data_r <= 8'h00; w_strb_r <= 1'b0;
      bresp_r <= `LUC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && !aw_hold_r) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_r) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_strb_r <= s_axi_wstrb[0];
      end
      if (wr_do) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (aw_addr_r[5:2] <= `LUC_LAST_IDX) ? `LUC_RESP_OKAY : `LUC_RESP_SLV;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // read channel, data registered
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `LUC_RESP_OKAY;
    end else if (ce) begin
      if (rd_do) begin
        rvalid_r <= 1'b1;
        rdata_r  <= {24'h00_0000, rd_vec[s_axi_araddr[5:2]]};
        rresp_r  <= (s_axi_araddr[5:2] <= `LUC_LAST_IDX) ? `LUC_RESP_OKAY : `LUC_RESP_SLV;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* File: core/luc_cfg.svh */
// register offsets, field positions, reset values and axi response codes of the lin/uart controller
`ifndef LUC_CFG_SVH
`define LUC_CFG_SVH

// byte offsets on the axi4-lite bus, one aligned word each
`define LUC_OFF_CTRL   6'h00
`define LUC_OFF_STAT   6'h04
`define LUC_OFF_IEN    6'h08
`define LUC_OFF_ERR    6'h0c
`define LUC_OFF_BTR    6'h10
`define LUC_OFF_DIVL   6'h14
`define LUC_OFF_DIVH   6'h18
`define LUC_OFF_LEN    6'h1c
`define LUC_OFF_IDENT  6'h20
`define LUC_OFF_SEL    6'h24
`define LUC_OFF_DATA   6'h28
`define LUC_LAST_IDX   4'ha

// control register fields
`define LUC_CTRL_CMD2  2
`define LUC_CTRL_ENA   3
`define LUC_CTRL_CONF  4
`define LUC_CTRL_VER   6
`define LUC_CTRL_SWRES 7

// status register fields
`define LUC_STAT_RXOK  0
`define LUC_STAT_TXOK  1
`define LUC_STAT_ERR   3
`define LUC_STAT_BUSY  4

// error register fields
`define LUC_ERR_FRAME  3
`define LUC_ERR_OVR    5
`define LUC_ERR_ABORT  7

// buffer select fields
`define LUC_SEL_NOINC  3

// reset values
`define LUC_RST_BTR    8'h20
`define LUC_RST_IDENT  8'h80
`define LUC_RST_ZERO   8'h00

// axi responses
`define LUC_RESP_OKAY  2'h0
`define LUC_RESP_SLV   2'h2

`endif

/* File: core/luc_pkg.sv */
// types shared by the lin/uart controller
package luc_pkg;

  // lin command sequencer states
  typedef enum logic [1:0] {
    LS_IDLE,
    LS_THDR,
    LS_TRSP,
    LS_RRSP
  } luc_lin_state_t;

endpackage

/* File: testbench/luc_ctrl_monitor.sv */
// port checks for the lin/uart controller
`timescale 1ns/100ps
`default_nettype none
module luc_ctrl_monitor (
  input wire logic        sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
  input wire logic        s_axi_arready, s_axi_rvalid, s_axi_rready, serial_out_pin, busy_flag,
  input wire logic [5:0]  s_axi_awaddr,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [31:0] s_axi_rdata
);
  logic big_r;
  // remembers whether the last captured write address lies past the map
  always_ff @(posedge sys_clk) begin
    if (!rst_n) big_r <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready) big_r <= s_axi_awaddr[5:2] > 4'ha;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  reset_state_a: assert property (disable iff (1'b0)
    !rst_n |=> serial_out_pin && !busy_flag && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not at reset state");
  idle_line_a: assert property (!busy_flag [*3] |-> serial_out_pin)
    else $error("line moved while not busy");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && !s_axi_bvalid |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  addr_held_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second address taken");
  slverr_code_a: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp == (big_r ? 2'h2 : 2'h0))
    else $error("write response code wrong");
endmodule
`default_nettype wire

/* File: testbench/luc_line_model.sv */
// far-side serial line: sends 8n1 characters, captures 9 bits after each start bit
`timescale 1ns/100ps
`default_nettype none
module luc_line_model (
  input  wire logic sys_clk,
  input  wire logic serial_out_pin,
  output logic      serial_in_pin
);
  localparam int BIT_CLKS = 32; // default timing, divisor zero
  initial serial_in_pin = 1'b1;
  // start bit, data lsb first, chosen stop level; line then rests on its pull-up
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_in_pin <= f[i];
      repeat (BIT_CLKS) @(posedge sys_clk);
    end
    serial_in_pin <= 1'b1;
  endtask
  // waits for a start bit, then samples each data and parity bit at its centre
  task automatic recv(output logic [8:0] b, output logic ok);
    int n;
    n = 0;
    while (serial_out_pin && n < 500) begin
      @(posedge sys_clk);
      n++;
    end
    ok = !serial_out_pin;
    repeat (BIT_CLKS / 2) @(posedge sys_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CLKS) @(posedge sys_clk);
      b[i] = serial_out_pin;
    end
  endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the lin/uart controller
`timescale 1ns/100ps
`default_nettype none
`include "luc_cfg.svh"
module testbench;
  logic sys_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, lo, rx_ok;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic serial_in_pin, serial_out_pin, busy_flag;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, wrsp;
  logic [8:0] rx_b;
  int errors = 0, n_checks = 0, cyc = 0;
  always #10 sys_clk = ~sys_clk;
  luc_ctrl i_dut (.*);
  luc_line_model i_line (.sys_clk, .serial_out_pin, .serial_in_pin);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a; s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0; wrsp = s_axi_bresp;
  endtask
  task rd(input logic [5:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0; rdv = s_axi_rdata; rsp = s_axi_rresp;
  endtask
  task t_reset;
    logic [7:0] ex [11] = '{0, 0, 0, 0, 8'h20, 0, 0, 0, 8'h80, 0, 0};
    for (int i = 0; i < 11; i++) begin
      rd(6'(i * 4)); chk(rdv, {24'h0, ex[i]});
    end
    rd(6'h2c); chk(rsp, 2'h2); chk(rdv, 0);
    wr(6'h30, 8'h11); chk(wrsp, 2'h2);
    $display("reset values done");
  endtask
  task t_rx;
    wr(`LUC_OFF_CTRL, 8'h0e); // uart, receive only
    i_line.send(8'h5a, 1'b1); repeat (40) @(posedge sys_clk);
    i_line.send(8'h33, 1'b1); repeat (8) @(posedge sys_clk);
    rd(`LUC_OFF_STAT); chk(rdv & 1, 1);
    rd(`LUC_OFF_DATA); chk(rdv, 32'h33);
    rd(`LUC_OFF_ERR); chk(rdv, 32'h20);
    rd(`LUC_OFF_STAT); chk(rdv & 1, 0);
    wr(`LUC_OFF_STAT, 8'h08); i_line.send(8'h0f, 1'b0); repeat (8) @(posedge sys_clk);
    rd(`LUC_OFF_ERR); chk(rdv & 8, 8);
    wr(`LUC_OFF_STAT, 8'h09); rd(`LUC_OFF_STAT); chk(rdv & 9, 0);
    $display("receive done");
  endtask
  task t_tx;
    wr(`LUC_OFF_CTRL, 8'h1d); // uart, transmit only, even parity
    fork
      i_line.recv(rx_b, rx_ok);
      begin
        wr(`LUC_OFF_DATA, 8'ha5); rd(`LUC_OFF_STAT); chk(rdv & 8'h12, 8'h10);
        wr(`LUC_OFF_DATA, 8'h3c);
      end
    join
    chk({rx_ok, rx_b}, {1'b1, 1'b0, 8'ha5});
    while (busy_flag) @(posedge sys_clk);
    repeat (8) @(posedge sys_clk);
    chk(busy_flag, 0);
    rd(`LUC_OFF_STAT); chk(rdv & 8'h12, 8'h02);
    $display("transmit done");
  endtask
  task t_listen;
    wr(`LUC_OFF_CTRL, 8'h3f); wr(`LUC_OFF_DATA, 8'h96); lo = 1'b0;
    repeat (360) begin
      @(posedge sys_clk);
      lo = lo | !serial_out_pin;
    end
    chk(lo, 0);
    rd(`LUC_OFF_STAT); chk(rdv & 3, 3);
    rd(`LUC_OFF_DATA); chk(rdv, 32'h96);
    $display("listening done");
  endtask
  task t_lin;
    wr(`LUC_OFF_CTRL, 8'h09); wr(`LUC_OFF_CTRL, 8'h0b); chk(busy_flag, 1);
    wr(`LUC_OFF_DIVL, 8'h55);
    wr(`LUC_OFF_CTRL, 8'h08);
    ce <= 1'b0;
    repeat (400) @(posedge sys_clk);
    chk(busy_flag, 1);
    ce <= 1'b1;
    while (busy_flag) @(posedge sys_clk);
    rd(`LUC_OFF_ERR); chk(rdv, 32'ha0);
    rd(`LUC_OFF_DIVL); chk(rdv, 0);
    $display("lin commands done");
  endtask
  task t_swres;
    logic [5:0] ad [7] = '{6'h00, 6'h08, 6'h10, 6'h14, 6'h18, 6'h20, 6'h24};
    logic [7:0] wv [7] = '{8'h80, 8'hff, 8'h08, 8'h12, 8'h03, 8'h3f, 8'hff};
    logic [7:0] ex [7] = '{8'h00, 8'hf0, 8'h20, 8'h12, 8'h03, 8'h80, 8'hf0};
    for (int i = 6; i >= 0; i--) wr(ad[i], wv[i]);
    for (int i = 0; i < 7; i++) begin
      rd(ad[i]); chk(rdv, {24'h0, ex[i]});
    end
    $display("soft reset done");
  endtask
  task t_core;
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`LUC_OFF_DIVL); chk(rdv, 0);
    $display("core reset done");
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 10000) begin
      errors++;
      close_out;
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset; t_rx; t_tx; t_listen; t_lin; t_swres; t_core;
    close_out;
  end
endmodule
bind luc_ctrl luc_ctrl_monitor i_mon (.*);
`default_nettype wire
